// ---- design/tmll_map.vh ----
// constants for the test-mode life-cycle lock block
`ifndef TMLL_MAP_VH
`define TMLL_MAP_VH
// command codes on the test command port
`define TMLL_CMD_AUTH      4'h1
`define TMLL_CMD_TO_NORMAL 4'h2
`define TMLL_CMD_TRACE_WR  4'h3
`define TMLL_CMD_SELFTEST  4'h4
`define TMLL_CMD_CKSUM_CLR 4'h5
`define TMLL_CMD_CKSUM_ADD 4'h6
`define TMLL_CMD_RD_ID     4'h7
// answer status codes
`define TMLL_ST_OK         4'h0
`define TMLL_ST_REJECT     4'h1
`define TMLL_ST_BADPW      4'h2
`define TMLL_ST_BADCMD     4'h3
// nonvolatile life-cycle code meaning normal mode; anything else is test
`define TMLL_LC_NORMAL     8'hA5
`define TMLL_LC_W          8
// widths and trace memory depth
`define TMLL_DATA_W        32
`define TMLL_TRACE_DEPTH   8
`define TMLL_TRACE_AW      3
// arbitrary neutral identifiers
`define TMLL_ID_SILICON    32'h0000_0101
`define TMLL_ID_TESTCODE   32'h0000_0201
`define TMLL_ID_BOOTLDR    32'h0000_0301
`define TMLL_PASSWORD      32'h1234_5678
`endif

// ---- design/tmll_lock.v ----
// test-mode life-cycle lock: authentication, one-way normal switch, command gating
// Overview of operation
// - test mode needs correct password first
// - switch to normal is one way
// - normal mode rejects every test command
// - functional tests only allowed in test mode
// - self-test and checksum over software image
// - traceability data writable only in test
// - silicon and firmware version identifiers readable
`timescale 1ns/1ns
`default_nettype none
`include "tmll_map.vh"
module tmll_lock (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // nonvolatile life-cycle cell
  input wire [`TMLL_LC_W-1:0] i_nv_lc,
  input wire i_nv_lc_valid,
  output reg o_nv_lc_wr,
  output reg [`TMLL_LC_W-1:0] o_nv_lc_wdata,
  // test command port
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_op,
  input wire [`TMLL_TRACE_AW-1:0] i_cmd_addr,
  input wire [`TMLL_DATA_W-1:0] i_cmd_data,
  // answer
  output reg o_rsp_valid,
  output reg [3:0] o_rsp_status,
  output reg [`TMLL_DATA_W-1:0] o_rsp_data,
  // self-test engine handshake
  output reg o_selftest_start,
  input wire i_selftest_done,
  input wire i_selftest_pass,
  // state
  output reg o_ready,
  output reg o_test_mode,
  output reg o_test_auth
);
  localparam ST_RESTORE = 2'h0;
  localparam ST_TEST = 2'h1;
  localparam ST_NORMAL = 2'h2;
  // every asynchronous pin bit goes through the same two-stage synchroniser
  localparam SYNC_W = `TMLL_LC_W + 3;

  reg [1:0] state_q;
  reg auth_q;
  reg [`TMLL_DATA_W-1:0] cksum_q;
  reg [`TMLL_DATA_W-1:0] trace_mem [0:`TMLL_TRACE_DEPTH-1];
  wire [SYNC_W-1:0] pin_raw;
  wire [SYNC_W-1:0] pin_sync;
  wire nv_valid_sync;
  wire [`TMLL_LC_W-1:0] nv_lc_sync;
  wire st_done_sync;
  wire st_pass_sync;
  wire st_done_rise;
  reg nv_valid_seen_q;
  reg st_done_seen_q;
  reg st_busy_q;
  reg st_pass_q;

  // test-only commands are everything but the id read
  function is_test_only;
    input [3:0] op;
    begin
      is_test_only = (op != `TMLL_CMD_RD_ID);
    end
  endfunction

  function [`TMLL_DATA_W-1:0] id_word;
    input [`TMLL_TRACE_AW-1:0] sel;
    begin
      if (sel == 3'h0) begin
        id_word = `TMLL_ID_SILICON;
      end else if (sel == 3'h1) begin
        id_word = `TMLL_ID_TESTCODE;
      end else if (sel == 3'h2) begin
        id_word = `TMLL_ID_BOOTLDR;
      end else begin
        id_word = {`TMLL_DATA_W{1'b0}};
      end
    end
  endfunction

  // rotate-and-add keeps word order significant
  function [`TMLL_DATA_W-1:0] cksum_step;
    input [`TMLL_DATA_W-1:0] acc;
    input [`TMLL_DATA_W-1:0] word;
    begin
      cksum_step = {acc[`TMLL_DATA_W-2:0], acc[`TMLL_DATA_W-1]} + word;
    end
  endfunction

  // pins from the self-test engine and nonvolatile controller are asynchronous
  assign pin_raw = {i_nv_lc_valid, i_nv_lc, i_selftest_done, i_selftest_pass};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge i_ref_clk) begin
        s1_q <= pin_raw[g];
        s2_q <= s1_q;
      end
      assign pin_sync[g] = s2_q;
    end
  endgenerate

  assign nv_valid_sync = pin_sync[SYNC_W-1];
  assign nv_lc_sync = pin_sync[SYNC_W-2:2];
  assign st_done_sync = pin_sync[1];
  assign st_pass_sync = pin_sync[0];

  // the code bits may resolve a cycle after valid, so the code is read
  // only once valid has been seen on two edges running
  // done stays high after a run; only its rising edge may end the next run,
  // or a stale done would close a fresh run at once with the old verdict
  always @(posedge i_ref_clk) begin
    nv_valid_seen_q <= nv_valid_sync;
    st_done_seen_q <= st_done_sync;
  end
  assign st_done_rise = st_done_sync && !st_done_seen_q;

  // trace memory has no reset; contents are nonvolatile image
  always @(posedge i_ref_clk) begin
    if (!i_srst && state_q == ST_TEST && auth_q && i_cmd_valid &&
        i_cmd_op == `TMLL_CMD_TRACE_WR) begin
      trace_mem[i_cmd_addr] <= i_cmd_data;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= ST_RESTORE;
      auth_q <= 1'b0;
      cksum_q <= {`TMLL_DATA_W{1'b0}};
      st_busy_q <= 1'b0;
      st_pass_q <= 1'b0;
      o_nv_lc_wr <= 1'b0;
      o_nv_lc_wdata <= {`TMLL_LC_W{1'b0}};
      o_rsp_valid <= 1'b0;
      o_rsp_status <= `TMLL_ST_OK;
      o_rsp_data <= {`TMLL_DATA_W{1'b0}};
      o_selftest_start <= 1'b0;
      o_ready <= 1'b0;
      o_test_mode <= 1'b0;
      o_test_auth <= 1'b0;
    end else begin
      o_nv_lc_wr <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_selftest_start <= 1'b0;
      if (st_busy_q && st_done_rise) begin
        st_busy_q <= 1'b0;
        st_pass_q <= st_pass_sync;
      end
      case (state_q)
        ST_RESTORE: begin
          // commands before restore are dropped silently
          if (nv_valid_sync && nv_valid_seen_q) begin
            if (nv_lc_sync == `TMLL_LC_NORMAL) begin
              state_q <= ST_NORMAL;
            end else begin
              state_q <= ST_TEST;
              o_test_mode <= 1'b1;
            end
            o_ready <= 1'b1;
          end
        end
        ST_TEST: begin
          if (i_cmd_valid) begin
            o_rsp_valid <= 1'b1;
            o_rsp_status <= `TMLL_ST_OK;
            o_rsp_data <= {`TMLL_DATA_W{1'b0}};
            if (i_cmd_op == `TMLL_CMD_AUTH) begin
              auth_q <= (i_cmd_data == `TMLL_PASSWORD);
              o_test_auth <= (i_cmd_data == `TMLL_PASSWORD);
              if (i_cmd_data != `TMLL_PASSWORD) begin
                o_rsp_status <= `TMLL_ST_BADPW;
              end
            end else if (i_cmd_op == `TMLL_CMD_RD_ID) begin
              o_rsp_data <= id_word(i_cmd_addr);
            end else if (!auth_q) begin
              o_rsp_status <= `TMLL_ST_REJECT;
            end else if (i_cmd_op == `TMLL_CMD_TO_NORMAL) begin
              state_q <= ST_NORMAL;
              auth_q <= 1'b0;
              o_test_auth <= 1'b0;
              o_test_mode <= 1'b0;
              o_nv_lc_wr <= 1'b1;
              o_nv_lc_wdata <= `TMLL_LC_NORMAL;
            end else if (i_cmd_op == `TMLL_CMD_TRACE_WR) begin
              o_rsp_data <= i_cmd_data;
            end else if (i_cmd_op == `TMLL_CMD_SELFTEST) begin
              if (!st_busy_q) begin
                o_selftest_start <= 1'b1;
                st_busy_q <= 1'b1;
              end
              o_rsp_data <= {{(`TMLL_DATA_W-2){1'b0}}, st_busy_q, st_pass_q};
            end else if (i_cmd_op == `TMLL_CMD_CKSUM_CLR) begin
              cksum_q <= {`TMLL_DATA_W{1'b0}};
            end else if (i_cmd_op == `TMLL_CMD_CKSUM_ADD) begin
              cksum_q <= cksum_step(cksum_q, i_cmd_data);
              o_rsp_data <= cksum_step(cksum_q, i_cmd_data);
            end else begin
              o_rsp_status <= `TMLL_ST_BADCMD;
            end
          end
        end
        ST_NORMAL: begin
          // no branch leaves this state except reset, which restores normal again
          if (i_cmd_valid) begin
            o_rsp_valid <= 1'b1;
            if (i_cmd_op == `TMLL_CMD_RD_ID) begin
              o_rsp_status <= `TMLL_ST_OK;
              o_rsp_data <= (i_cmd_addr[`TMLL_TRACE_AW-1]) ?
                            trace_mem[i_cmd_addr] : id_word(i_cmd_addr);
            end else if (is_test_only(i_cmd_op)) begin
              o_rsp_status <= `TMLL_ST_REJECT;
              o_rsp_data <= {`TMLL_DATA_W{1'b0}};
            end
          end
        end
        default: begin
          state_q <= ST_NORMAL;
          o_test_mode <= 1'b0;
        end
      endcase
    end
  end
endmodule // tmll_lock
`default_nettype wire

// ---- verification/tmll_lock_sva.sv ----
// checker for the life-cycle lock ports
`timescale 1ns/1ns
`default_nettype none
`include "tmll_map.vh"
module tmll_lock_sva (
  input wire i_ref_clk, i_srst, i_nv_lc_valid, i_cmd_valid, i_selftest_done, i_selftest_pass,
  input wire [7:0] i_nv_lc, o_nv_lc_wdata,
  input wire [3:0] i_cmd_op, o_rsp_status,
  input wire [2:0] i_cmd_addr,
  input wire [31:0] i_cmd_data, o_rsp_data,
  input wire o_nv_lc_wr, o_rsp_valid, o_selftest_start, o_ready, o_test_mode, o_test_auth
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  wire tk = i_cmd_valid && o_ready;
  property p_auth; $rose(o_test_auth) |-> $past(i_cmd_op) == `TMLL_CMD_AUTH &&
    $past(i_cmd_data) == `TMLL_PASSWORD; endproperty
  a_auth: assert property (p_auth) else $error("auth without password");
  property p_oneway; o_ready && !o_test_mode |=> !o_test_mode; endproperty
  a_oneway: assert property (p_oneway) else $error("back to test mode");
  property p_rej; tk && !o_test_mode && i_cmd_op != `TMLL_CMD_RD_ID |=>
    o_rsp_valid && o_rsp_status == `TMLL_ST_REJECT; endproperty
  a_rej: assert property (p_rej) else $error("normal mode accepted");
  property p_start; o_selftest_start |-> o_test_auth && $past(i_cmd_op) == `TMLL_CMD_SELFTEST;
  endproperty
  a_start: assert property (p_start) else $error("stray self-test");
  property p_nvwr; o_nv_lc_wr |-> o_nv_lc_wdata == `TMLL_LC_NORMAL && !o_test_mode; endproperty
  a_nvwr: assert property (p_nvwr) else $error("bad nv write");
  property p_trace; tk && o_test_mode && !o_test_auth && i_cmd_op == `TMLL_CMD_TRACE_WR |=>
    o_rsp_status == `TMLL_ST_REJECT; endproperty
  a_trace: assert property (p_trace) else $error("trace write unauthorised");
  property p_id; tk && i_cmd_op == `TMLL_CMD_RD_ID && i_cmd_addr == 3'h0 |=>
    o_rsp_data == `TMLL_ID_SILICON; endproperty
  a_id: assert property (p_id) else $error("bad silicon id");
  property p_rdy; $rose(o_ready) |-> o_test_mode == (i_nv_lc != `TMLL_LC_NORMAL); endproperty
  a_rdy: assert property (p_rdy) else $error("state not restored");
  property p_ign; i_cmd_valid && !o_ready |=> !o_rsp_valid; endproperty
  a_ign: assert property (p_ign) else $error("answer before ready");
  c_auth: cover property ($rose(o_test_auth));
  c_norm: cover property ($fell(o_test_mode));
  c_st: cover property (o_selftest_start);
endmodule // tmll_lock_sva
bind tmll_lock tmll_lock_sva u_sva (.*);
`default_nettype wire

// ---- verification/tmll_env_model.sv ----
// nonvolatile cell and self-test engine beside the lock
`timescale 1ns/1ns
`default_nettype none
module tmll_env_model (
  input wire logic i_ref_clk, i_srst, o_nv_lc_wr, o_selftest_start, i_pass_sel,
  input wire logic [7:0] o_nv_lc_wdata,
  output logic [7:0] i_nv_lc,
  output logic i_nv_lc_valid,
  output logic i_selftest_done = 0,
  output logic i_selftest_pass = 0
);
  // the cell ignores reset on purpose: it is what keeps normal mode
  logic [7:0] cell_q = 8'h00;
  logic [1:0] rc_q = 2'h0;
  logic [2:0] st_q = 3'h0;
  always @(posedge i_ref_clk) begin
    if (o_nv_lc_wr) cell_q <= o_nv_lc_wdata;
    if (i_srst) rc_q <= 2'h0;
    else if (rc_q != 2'h3) rc_q <= rc_q + 2'h1;
    if (o_selftest_start) begin
      st_q <= 3'h5;
      i_selftest_done <= 1'b0;
    end else if (st_q == 3'h1) begin
      st_q <= 3'h0;
      i_selftest_done <= 1'b1;
      i_selftest_pass <= i_pass_sel;
    end else if (st_q != 3'h0) st_q <= st_q - 3'h1;
  end
  assign i_nv_lc_valid = rc_q == 2'h3;
  // unreadable cell shows garbage, not the stored code
  assign i_nv_lc = i_nv_lc_valid ? cell_q : ~cell_q;
endmodule // tmll_env_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// testbench for the life-cycle lock
`timescale 1ns/1ns
`default_nettype none
`include "tmll_map.vh"
module tb_top;
  logic i_ref_clk = 0, i_srst = 1, i_cmd_valid = 0, i_pass_sel = 1;
  logic [3:0] i_cmd_op = '0;
  logic [2:0] i_cmd_addr = '0;
  logic [31:0] i_cmd_data = '0, rnd = 32'hd85f_6a04, tr, ck;
  wire [7:0] i_nv_lc, o_nv_lc_wdata;
  wire i_nv_lc_valid, i_selftest_done, i_selftest_pass, o_nv_lc_wr, o_rsp_valid;
  wire o_selftest_start, o_ready, o_test_mode, o_test_auth;
  wire [3:0] o_rsp_status;
  wire [31:0] o_rsp_data;
  int num_errors = 0, num_checks = 0, starts = 0;
  tmll_lock tmll_lock_inst (.*);
  tmll_env_model tmll_env_model_inst (.*);
  initial forever #10 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_selftest_start === 1'b1) starts++;
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] exp_id(input logic [2:0] a);
    if (a == 3'h0) return `TMLL_ID_SILICON;
    if (a == 3'h1) return `TMLL_ID_TESTCODE;
    if (a == 3'h2) return `TMLL_ID_BOOTLDR;
    return 32'h0000_0000;
  endfunction
  task chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rst;
    i_srst <= 1;
    repeat (20) @(posedge i_ref_clk);
    i_srst <= 0;
    // a command while the life-cycle is still being restored must get no answer
    @(posedge i_ref_clk);
    {i_cmd_valid, i_cmd_op, i_cmd_data} <= {1'b1, `TMLL_CMD_AUTH, `TMLL_PASSWORD};
    @(posedge i_ref_clk);
    i_cmd_valid <= 0;
    #1 chk(o_rsp_valid, 0);
    for (int k = 0; k < 50 && o_ready !== 1'b1; k++) @(posedge i_ref_clk) #1;
    if (o_ready !== 1'b1) begin
      num_errors++;
      test_done;
    end
  endtask
  task cmd(input logic [3:0] op, input logic [2:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge i_ref_clk);
    {i_cmd_valid, i_cmd_op, i_cmd_addr, i_cmd_data} <= {1'b1, op, a, d};
    @(posedge i_ref_clk);
    i_cmd_valid <= 0;
    #1 chk(o_rsp_valid, 1);
    chk(o_rsp_status, st);
  endtask
  initial begin
    rst;
    chk({o_test_mode, o_test_auth}, 2'h2);
    cmd(`TMLL_CMD_TRACE_WR, 3'h4, rnd, `TMLL_ST_REJECT);
    cmd(`TMLL_CMD_SELFTEST, 3'h0, rnd, `TMLL_ST_REJECT);
    cmd(`TMLL_CMD_AUTH, 3'h0, rnd, `TMLL_ST_BADPW);
    cmd(`TMLL_CMD_AUTH, 3'h0, `TMLL_PASSWORD, `TMLL_ST_OK);
    chk(o_test_auth, 1);
    cmd(4'h0, 3'h0, rnd, `TMLL_ST_BADCMD);
    for (int a = 0; a < 4; a++) begin
      cmd(`TMLL_CMD_RD_ID, a[2:0], rnd, `TMLL_ST_OK);
      chk(o_rsp_data, exp_id(a[2:0]));
    end
    tr = lfsr(rnd);
    cmd(`TMLL_CMD_TRACE_WR, 3'h4, tr, `TMLL_ST_OK);
    chk(o_rsp_data, tr);
    // first run starts, a second request while busy only reports status
    cmd(`TMLL_CMD_SELFTEST, 3'h0, rnd, `TMLL_ST_OK);
    chk(o_rsp_data, 32'h0000_0000);
    cmd(`TMLL_CMD_SELFTEST, 3'h0, rnd, `TMLL_ST_OK);
    chk(o_rsp_data, 32'h0000_0002);
    repeat (12) @(posedge i_ref_clk);
    i_pass_sel <= 0;
    // the previous run's done is still high when the second run starts
    cmd(`TMLL_CMD_SELFTEST, 3'h0, rnd, `TMLL_ST_OK);
    chk(o_rsp_data, 32'h0000_0001);
    repeat (12) @(posedge i_ref_clk);
    cmd(`TMLL_CMD_SELFTEST, 3'h0, rnd, `TMLL_ST_OK);
    chk(o_rsp_data, 32'h0000_0000);
    cmd(`TMLL_CMD_CKSUM_CLR, 3'h0, rnd, `TMLL_ST_OK);
    ck = '0;
    repeat (4) begin
      rnd = lfsr(rnd);
      ck = {ck[30:0], ck[31]} + rnd;
      cmd(`TMLL_CMD_CKSUM_ADD, 3'h0, rnd, `TMLL_ST_OK);
      chk(o_rsp_data, ck);
    end
    cmd(`TMLL_CMD_TO_NORMAL, 3'h0, rnd, `TMLL_ST_OK);
    chk(o_test_mode, 0);
    chk(o_test_auth, 0);
    $display("test mode phase done");
    rst;
    chk(o_test_mode, 0);
    chk(o_test_auth, 0);
    for (int op = 0; op < 16; op++) begin
      if (op != 7) cmd(op[3:0], 3'h4, rnd, `TMLL_ST_REJECT);
    end
    cmd(`TMLL_CMD_AUTH, 3'h0, `TMLL_PASSWORD, `TMLL_ST_REJECT);
    chk({o_test_mode, o_test_auth}, 2'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      cmd(`TMLL_CMD_RD_ID, {1'b0, rnd[1:0]}, rnd, `TMLL_ST_OK);
      chk(o_rsp_data, exp_id({1'b0, rnd[1:0]}));
    end
    cmd(`TMLL_CMD_RD_ID, 3'h4, rnd, `TMLL_ST_OK);
    chk(o_rsp_data, tr);
    chk(starts, 3);
    $display("normal mode phase done");
    test_done;
  end
endmodule // tb_top
`default_nettype wire
